// ==== lacfg_regs.sv ====
// latency/alarm configuration register bank with valid-time and lock one-shot timers
`timescale 1ns/1ps
`default_nettype none
module lacfg_regs #(
    parameter longint VT0_CYC = lacfg_pkg::VALID_TIME_0_CYC,
    parameter longint VT1_CYC = lacfg_pkg::VALID_TIME_1_CYC,
    parameter longint VT2_CYC = lacfg_pkg::VALID_TIME_2_CYC,
    parameter longint VT3_CYC = lacfg_pkg::VALID_TIME_3_CYC,
    parameter longint LT0_CYC = lacfg_pkg::RETRIG_0_CYC,
    parameter longint LT1_CYC = lacfg_pkg::RETRIG_1_CYC,
    parameter longint LT2_CYC = lacfg_pkg::RETRIG_2_CYC,
    parameter longint LT3_CYC = lacfg_pkg::RETRIG_3_CYC,
    parameter longint LT4_CYC = lacfg_pkg::RETRIG_4_CYC,
    parameter longint LT7_CYC = lacfg_pkg::RETRIG_7_CYC
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // register port (same clock domain)
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // monitored events (same clock domain)
    input wire logic clk_invalid_i,
    input wire logic phase_slip_i,
    input wire logic irq_state_i,
    // applied settings and alarms
    output logic [14:0] fine_latency_o,
    output logic clk_alarm_o,
    output logic lock_loss_status_o,
    // pins: value and output enable
    output logic lock_loss_output_o,
    output logic lock_loss_output_oe_o,
    output logic irq_out_o,
    output logic irq_out_oe_o
);
    import lacfg_pkg::*;

    localparam int CW = 30;

    // cycle count for a valid-time code
    function automatic logic [CW-1:0] vt_cycles(input logic [1:0] code);
        case (code)
            2'h0: vt_cycles = CW'(VT0_CYC);
            2'h1: vt_cycles = CW'(VT1_CYC);
            2'h2: vt_cycles = CW'(VT2_CYC);
            default: vt_cycles = CW'(VT3_CYC);
        endcase
    endfunction

    // cycle count for a retrigger code; reserved codes fall to the code 7 count, LT7_CYC, the shortest by default
    function automatic logic [CW-1:0] lt_cycles(input logic [2:0] code);
        case (code)
            3'h0: lt_cycles = CW'(LT0_CYC);
            3'h1: lt_cycles = CW'(LT1_CYC);
            3'h2: lt_cycles = CW'(LT2_CYC);
            3'h3: lt_cycles = CW'(LT3_CYC);
            3'h4: lt_cycles = CW'(LT4_CYC);
            default: lt_cycles = CW'(LT7_CYC);
        endcase
    endfunction

    logic [7:0] lat_high, lat_low, alarm_timing, pin_enable, rsvd_config;
    logic [7:0] next_lat_high, next_lat_low, next_alarm_timing, next_pin_enable;
    logic [7:0] next_rsvd_config, next_rdata;
    logic [14:0] held_latency, next_held_latency, next_fine_latency;
    logic [CW-1:0] vt_cnt, next_vt_cnt, lt_cnt, next_lt_cnt;
    logic clk_alarm, next_clk_alarm, lock_lost, next_lock_lost;
    logic [14:0] reg_latency;
    logic latency_valid;

    assign reg_latency = {lat_high[6:0], lat_low};
    assign latency_valid = lat_high[VALID_BIT];

    // register writes and read mux
    always_comb begin
        next_lat_high = lat_high;
        next_lat_low = lat_low;
        next_alarm_timing = alarm_timing;
        next_pin_enable = pin_enable;
        next_rsvd_config = rsvd_config;
        next_rdata = reg_rdata_o;
        if (reg_wr_i) begin
            case (reg_addr_i)
                LAT_HIGH_ADDR: next_lat_high = reg_wdata_i;
                LAT_LOW_ADDR: next_lat_low = reg_wdata_i;
                ALARM_TIMING_ADDR: next_alarm_timing = {3'h0, reg_wdata_i[4:0]};
                // reserved bits kept as written; software is expected to zero them
                PIN_ENABLE_ADDR: next_pin_enable = reg_wdata_i;
                RSVD_CONFIG_ADDR: next_rsvd_config = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                LAT_HIGH_ADDR: next_rdata = lat_high;
                LAT_LOW_ADDR: next_rdata = lat_low;
                ALARM_TIMING_ADDR: next_rdata = alarm_timing;
                PIN_ENABLE_ADDR: next_rdata = pin_enable;
                RSVD_CONFIG_ADDR: next_rdata = rsvd_config;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // latency hold: snapshot is refreshed only while valid, so a clear freezes it
    always_comb begin
        next_held_latency = held_latency;
        if (latency_valid) begin
            next_held_latency = reg_latency;
            next_fine_latency = reg_latency;
        end else begin
            next_fine_latency = held_latency;
        end
    end

    // valid-time qualifier: alarm clears only after a full clean interval
    always_comb begin
        next_vt_cnt = vt_cnt;
        next_clk_alarm = clk_alarm;
        if (clk_invalid_i) begin
            next_clk_alarm = 1'b1;
            next_vt_cnt = vt_cycles(alarm_timing[VALID_TIME_LSB +: 2]);
        end else if (clk_alarm) begin
            if (vt_cnt <= CW'(1)) begin
                next_clk_alarm = 1'b0;
                next_vt_cnt = '0;
            end else begin
                next_vt_cnt = vt_cnt - CW'(1);
            end
        end
    end

    // lock one-shot: every slip reloads the interval, expiry drops lock loss
    always_comb begin
        next_lt_cnt = lt_cnt;
        next_lock_lost = lock_lost;
        if (phase_slip_i) begin
            next_lock_lost = 1'b1;
            next_lt_cnt = lt_cycles(alarm_timing[RETRIG_LSB +: 3]);
        end else if (lock_lost) begin
            if (lt_cnt <= CW'(1)) begin
                next_lock_lost = 1'b0;
                next_lt_cnt = '0;
            end else begin
                next_lt_cnt = lt_cnt - CW'(1);
            end
        end
    end

    // state registers; enable low freezes everything
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lat_high <= LAT_HIGH_RST;
            lat_low <= LAT_LOW_RST;
            alarm_timing <= ALARM_TIMING_RST;
            pin_enable <= PIN_ENABLE_RST;
            rsvd_config <= RSVD_CONFIG_RST;
            reg_rdata_o <= 8'h00;
            held_latency <= 15'h0000;
            fine_latency_o <= 15'h0000;
            vt_cnt <= '0;
            clk_alarm <= 1'b0;
            lt_cnt <= '0;
            lock_lost <= 1'b0;
            clk_alarm_o <= 1'b0;
            lock_loss_status_o <= 1'b0;
            lock_loss_output_o <= 1'b0;
            lock_loss_output_oe_o <= 1'b0;
            irq_out_o <= 1'b0;
            irq_out_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            lat_high <= next_lat_high;
            lat_low <= next_lat_low;
            alarm_timing <= next_alarm_timing;
            pin_enable <= next_pin_enable;
            rsvd_config <= next_rsvd_config;
            reg_rdata_o <= next_rdata;
            held_latency <= next_held_latency;
            fine_latency_o <= next_fine_latency;
            vt_cnt <= next_vt_cnt;
            clk_alarm <= next_clk_alarm;
            lt_cnt <= next_lt_cnt;
            lock_lost <= next_lock_lost;
            clk_alarm_o <= next_clk_alarm;
            lock_loss_status_o <= next_lock_lost;
            lock_loss_output_o <= next_lock_lost;
            lock_loss_output_oe_o <= next_pin_enable[LOSS_PIN_BIT];
            irq_out_o <= irq_state_i;
            irq_out_oe_o <= next_pin_enable[IRQ_PIN_BIT];
        end
    end

    // checks
    a_hold_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i && !latency_valid && $past(clk_en_i) && !$past(latency_valid)
        |=> $stable(fine_latency_o)) else $error("latency moved while not valid");
    a_apply_latency: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i && latency_valid |=> fine_latency_o == $past(reg_latency))
        else $error("latency not taken from registers");
    a_field_split: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i && latency_valid |=> fine_latency_o[14:8] == $past(lat_high[6:0]))
        else $error("latency high field misplaced");
    a_valid_time_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i && clk_invalid_i
        |=> clk_alarm && vt_cnt == $past(vt_cycles(alarm_timing[VALID_TIME_LSB +: 2])))
        else $error("valid-time counter not loaded");
    a_alarm_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_alarm && vt_cnt > CW'(1) |=> clk_alarm) else $error("alarm cleared early");
    a_slip_retrig: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i && phase_slip_i
        |=> lock_lost && lt_cnt == $past(lt_cycles(alarm_timing[RETRIG_LSB +: 3])))
        else $error("one-shot not retriggered");
    a_reserved_retrig: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i && phase_slip_i && alarm_timing[RETRIG_LSB +: 3] inside {3'h5, 3'h6}
        |=> lt_cnt == CW'(LT7_CYC)) else $error("reserved retrigger code not shortest");
    a_loss_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i |=> lock_loss_output_oe_o == pin_enable[LOSS_PIN_BIT]
        && lock_loss_output_o == lock_lost) else $error("lock-loss pin wrong");
    // enable sampled on the edge that loads the register, so a write turning it on is legal
    a_irq_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        clk_en_i ##1 !pin_enable[IRQ_PIN_BIT] |-> !irq_out_oe_o)
        else $error("irq pin driven while disabled");
    a_reset_vals: assert property (@(posedge ref_clk_i)
        $rose(rst_b_i) |-> alarm_timing == ALARM_TIMING_RST && lat_high == LAT_HIGH_RST)
        else $error("reset values wrong");

    c_hold_write: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !latency_valid && reg_wr_i && reg_addr_i == LAT_LOW_ADDR);
    c_alarm_clear: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $fell(clk_alarm));
    c_loss_expire: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $fell(lock_lost));
    c_pin_off: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) $fell(irq_out_oe_o));
endmodule
`default_nettype wire

// ==== lacfg_pkg.sv ====
// package: register map, reset values, field positions and timing counts for the latency/alarm config
package lacfg_pkg;
    // register addresses on the device management port
    localparam logic [7:0] LAT_HIGH_ADDR = 8'h11;
    localparam logic [7:0] LAT_LOW_ADDR = 8'h12;
    localparam logic [7:0] ALARM_TIMING_ADDR = 8'h13;
    localparam logic [7:0] PIN_ENABLE_ADDR = 8'h14;
    localparam logic [7:0] RSVD_CONFIG_ADDR = 8'h15;
    // reset values
    localparam logic [7:0] LAT_HIGH_RST = 8'h80;
    localparam logic [7:0] LAT_LOW_RST = 8'h00;
    localparam logic [7:0] ALARM_TIMING_RST = 8'h2C;
    localparam logic [7:0] PIN_ENABLE_RST = 8'h3E;
    localparam logic [7:0] RSVD_CONFIG_RST = 8'hFF;
    // field positions
    localparam int VALID_BIT = 7;
    localparam int VALID_TIME_LSB = 3;
    localparam int RETRIG_LSB = 0;
    localparam int LOSS_PIN_BIT = 1;
    localparam int IRQ_PIN_BIT = 0;
    // clock rate and time units
    localparam longint CLK_HZ = 50000000;
    localparam longint US_CYC = CLK_HZ / 1000000;
    // valid times in microseconds
    localparam longint VALID_TIME_0_US = 2000;
    localparam longint VALID_TIME_1_US = 100000;
    localparam longint VALID_TIME_2_US = 200000;
    localparam longint VALID_TIME_3_US = 13000000;
    // retrigger intervals in nanoseconds
    localparam longint RETRIG_0_NS = 106000000;
    localparam longint RETRIG_1_NS = 53000000;
    localparam longint RETRIG_2_NS = 26500000;
    localparam longint RETRIG_3_NS = 13300000;
    localparam longint RETRIG_4_NS = 6600000;
    localparam longint RETRIG_7_NS = 833000;
    localparam longint NS_PER_CYC = 1000000000 / CLK_HZ;
    // cycle counts (least times round up, but these divide exactly at 50 MHz)
    localparam longint VALID_TIME_0_CYC = VALID_TIME_0_US * US_CYC;
    localparam longint VALID_TIME_1_CYC = VALID_TIME_1_US * US_CYC;
    localparam longint VALID_TIME_2_CYC = VALID_TIME_2_US * US_CYC;
    localparam longint VALID_TIME_3_CYC = VALID_TIME_3_US * US_CYC;
    localparam longint RETRIG_0_CYC = RETRIG_0_NS / NS_PER_CYC;
    localparam longint RETRIG_1_CYC = RETRIG_1_NS / NS_PER_CYC;
    localparam longint RETRIG_2_CYC = RETRIG_2_NS / NS_PER_CYC;
    localparam longint RETRIG_3_CYC = RETRIG_3_NS / NS_PER_CYC;
    localparam longint RETRIG_4_CYC = RETRIG_4_NS / NS_PER_CYC;
    localparam longint RETRIG_7_CYC = RETRIG_7_NS / NS_PER_CYC;
endpackage

// ==== lacfg_host.sv ====
// host model driving the register port of the latency and alarm bank
`timescale 1ns/1ps
`default_nettype none
module lacfg_host (
    // clock
    input wire logic clk_i,
    // register port strobes, address and data
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    import lacfg_pkg::*;

    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // one strobe cycle; idle bus shows inverted bits so stale values cannot match
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_o <= wr;
        rd_o <= ~wr;
        addr_o <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    // valid cleared in the same write as the high latency bits, before the low byte changes
    task automatic lat_bytes(input logic [14:0] v);
        xfer(1'b1, LAT_HIGH_ADDR, {1'b0, v[14:8]});
        xfer(1'b1, LAT_LOW_ADDR, v[7:0]);
    endtask
    // valid set only once every byte is in
    task automatic lat_commit(input logic [14:0] v);
        xfer(1'b1, LAT_HIGH_ADDR, {1'b1, v[14:8]});
    endtask
    // reserved pin-enable bits always written as zero
    task automatic pin_en(input logic loss, input logic irq);
        xfer(1'b1, PIN_ENABLE_ADDR, {6'h00, loss, irq});
    endtask
endmodule
`default_nettype wire

// ==== tb_latency_and_alarm_pin_config.sv ====
// self-checking bench for the latency and alarm configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_latency_and_alarm_pin_config;
    import lacfg_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, inval = 1'b0, slip = 1'b0, irq = 1'b0;
    logic wr, rd, rd_seen = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic [14:0] lat, prev;
    logic alarm, loss_st, loss_pin, loss_oe, irq_pin, irq_oe;
    logic [7:0] exp_q[$];
    int n_fail = 0, cmp_count = 0, cyc = 0, seed = 47;
    // shortened counts so that every interval fits in the run
    localparam int VT0 = 20, VT1 = 30, VT2 = 40, VT3 = 50;
    localparam int LT0 = 10, LT1 = 20, LT2 = 30, LT3 = 40, LT4 = 50, LT7 = 60;
    int vt[4] = '{VT0, VT1, VT2, VT3};
    // reserved codes 5 and 6 expect the code 7 interval, LT7, which is the longest of the shortened counts here
    int lt[8] = '{LT0, LT1, LT2, LT3, LT4, LT7, LT7, LT7};
    lacfg_host host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    lacfg_regs #(.VT0_CYC(VT0), .VT1_CYC(VT1), .VT2_CYC(VT2), .VT3_CYC(VT3), .LT0_CYC(LT0),
        .LT1_CYC(LT1), .LT2_CYC(LT2), .LT3_CYC(LT3), .LT4_CYC(LT4), .LT7_CYC(LT7)) dut (
        .ref_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .clk_invalid_i(inval), .phase_slip_i(slip), .irq_state_i(irq),
        .fine_latency_o(lat), .clk_alarm_o(alarm), .lock_loss_status_o(loss_st),
        .lock_loss_output_o(loss_pin), .lock_loss_output_oe_o(loss_oe),
        .irq_out_o(irq_pin), .irq_out_oe_o(irq_oe));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // read data lands one edge after the strobe; oldest note is its expectation
    always @(posedge clk) begin
        if (rd_seen) check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
        rd_seen <= rd & en & rst_b;
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 8'h00);
    endtask
    // one-cycle event loaded at edge 1; alarm high through edge n, low from edge n+1
    task automatic pulse(input bit lock, input int n);
        @(posedge clk);
        if (lock) slip <= 1'b1;
        else inval <= 1'b1;
        @(posedge clk);
        slip <= 1'b0;
        inval <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("alarm_hi", 16'h0001, {15'h0000, lock ? loss_st : alarm});
        if (lock) check("loss_pin", 16'h0001, {15'h0000, loss_pin});
        repeat (n - 3) @(posedge clk);
        #1 check("alarm_hold", 16'h0001, {15'h0000, lock ? loss_st : alarm});
        @(posedge clk);
        #1 check("alarm_lo", 16'h0000, {15'h0000, lock ? loss_st : alarm});
        if (lock) check("loss_pin_lo", 16'h0000, {15'h0000, loss_pin});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 check("lat_rst", 16'h0000, {1'b0, lat});
        check("oe_rst", 16'h0002, {14'h0000, loss_oe, irq_oe});
        rd_chk(LAT_HIGH_ADDR, 8'h80);
        rd_chk(LAT_LOW_ADDR, 8'h00);
        rd_chk(ALARM_TIMING_ADDR, 8'h2C);
        rd_chk(PIN_ENABLE_ADDR, 8'h3E);
        rd_chk(RSVD_CONFIG_ADDR, 8'hFF);
        rd_chk(8'h16, 8'h00);
        prev = 15'h0000;
        for (int i = 0; i < 4; i++) begin
            host.lat_bytes(15'($random(seed)));
            @(posedge clk);
            #1 check("lat_held", {1'b0, prev}, {1'b0, lat});
            prev = 15'((i == 3) ? 15'h4000 : 15'($random(seed)));
            host.lat_bytes(prev);
            host.lat_commit(prev);
            @(posedge clk);
            #1 check("lat_new", {1'b0, prev}, {1'b0, lat});
        end
        host.xfer(1'b1, ALARM_TIMING_ADDR, 8'hFF);
        rd_chk(ALARM_TIMING_ADDR, 8'h1F);
        for (int c = 0; c < 4; c++) begin
            host.xfer(1'b1, ALARM_TIMING_ADDR, 8'(c << 3));
            pulse(1'b0, vt[c]);
        end
        for (int c = 0; c < 8; c++) begin
            host.xfer(1'b1, ALARM_TIMING_ADDR, 8'(c));
            pulse(1'b1, lt[c]);
        end
        for (int p = 0; p < 4; p++) begin
            host.pin_en(p[1], p[0]);
            @(posedge clk);
            irq <= 1'($random(seed));
            @(posedge clk);
            #1 check("oe", {14'h0000, 2'(p)}, {14'h0000, loss_oe, irq_oe});
            check("irq_pin", {15'h0000, irq}, {15'h0000, irq_pin});
        end
        @(posedge clk);
        en <= 1'b0;
        host.xfer(1'b1, ALARM_TIMING_ADDR, 8'h15);
        @(posedge clk);
        en <= 1'b1;
        rd_chk(ALARM_TIMING_ADDR, 8'h07);
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
